/* hw/flash_host_defines.vh */
/*
 constants for the parallel flash bus host: pin widths, timing counts,
 sector protect address bit positions, operation codes.
 assumes a 50 MHz system clock.
*/
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

// clock period in ns
`define CLK_PERIOD_NS 20
// access time in ns, rounded up to cycles
`define ACCESS_NS 70
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// write strobe low time in ns, rounded up
`define STROBE_NS 40
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reset pulse low time in ns, rounded up
`define RESET_PULSE_NS 500
`define RESET_PULSE_CYC ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// recovery after any cycle, in cycles
`define RECOVER_CYC 2
// counter width
`define CNT_W 6

// address and data widths
`define ADDR_W 20
`define DATA_W 16

// protect address bit positions and levels
`define PROT_BIT_SEL 6
`define PROT_BIT_ONE 1
`define PROT_BIT_ZERO 0

// operation codes on op_code
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_PROTECT 3'h2
`define OP_UNPROTECT 3'h3
`define OP_RESET 3'h4

`endif

/* hw/flash_sample_sync.v */
/*
 two flip-flop synchroniser for a vector of pin inputs.
 assumes the inputs come from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_sample_sync #(
   parameter W = 17
) (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // raw and synced values
   input wire [W-1:0] raw_in,
   output reg [W-1:0] sync_out
);

   reg [W-1:0] meta_reg;

   // two stages, first read only by second
   always @(posedge clk) begin
      if (!reset_n) begin
         meta_reg <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_reg <= raw_in;
         sync_out <= meta_reg;
      end
   end

endmodule // flash_sample_sync
`default_nettype wire

/* hw/flash_bus_host.v */
/*
 host side controller for an asynchronous boot sector flash bus.
 runs read, write, sector protect, unprotect and hardware reset cycles,
 reads and writes in word or byte width, with an optional high voltage reset for
 temporary unprotect. assumes a board level driver turns
 high_voltage_level into the elevated reset level, and that the
 data pins resolve from the output enables outside this module.
*/
// What this block does
// - read: select, output enable low, reset high
// - write: select low, oe high, strobe low
// - strobe stays high through reads
// - word twenty bit, byte adds low bit
// - protect: high voltage, bit6 low, 1 high, 0 low
// - unprotect: same, bit6 high
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defines.vh"

module flash_bus_host (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // user request
   input wire req_valid,
   input wire [2:0] op_code,
   input wire [`ADDR_W:0] req_addr,
   input wire [`DATA_W-1:0] req_wdata,
   input wire byte_mode,
   input wire temp_unprotect,
   input wire boot_lock,
   output reg req_ready,
   output reg rsp_valid,
   output reg [`DATA_W-1:0] rsp_rdata,
   output reg flash_busy,
   // flash control pins, active low except high_voltage_level and word_sel
   output reg chip_en_n,
   output reg out_en_n,
   output reg wr_strobe_n,
   output reg hw_reset_n,
   output reg high_voltage_level,
   output reg word_sel,
   output reg write_protect_n,
   output reg [`ADDR_W-1:0] addr_out,
   // flash data pins as three signals
   input wire [`DATA_W-1:0] data_in,
   output reg [`DATA_W-1:0] data_out,
   output reg [`DATA_W-1:0] data_oe,
   // ready/busy from the device
   input wire ready_busy_out
);

   localparam ST_IDLE = 3'h0;
   localparam ST_READ = 3'h1;
   localparam ST_WRITE = 3'h2;
   localparam ST_RESET = 3'h3;
   localparam ST_RECOVER = 3'h4;

   reg [2:0] state_reg;
   reg [`CNT_W-1:0] cnt_reg;
   reg [2:0] op_reg;
   wire [`DATA_W:0] sync_val;
   wire [`DATA_W-1:0] data_sync;
   wire busy_sync;

   // pad the pin inputs through two flops
   flash_sample_sync #(
      .W(`DATA_W + 1)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .raw_in({ready_busy_out, data_in}),
      .sync_out(sync_val)
   );
   assign data_sync = sync_val[`DATA_W-1:0];
   assign busy_sync = ~sync_val[`DATA_W];

   // address for word or byte mode
   function [`ADDR_W-1:0] pin_addr;
      input [`ADDR_W:0] a;
      input bm;
      begin
         if (bm)
            pin_addr = a[`ADDR_W:1];
         else
            pin_addr = a[`ADDR_W-1:0];
      end
   endfunction

   // data pin enables for a write in the given width
   function [`DATA_W-1:0] wr_enables;
      input bm;
      begin
         if (bm)
            wr_enables = 16'h80ff; // pin 15 drives the lsb
         else
            wr_enables = 16'hffff;
      end
   endfunction

   // protect address with fixed low bits
   function [`ADDR_W-1:0] prot_addr;
      input [`ADDR_W-1:0] a;
      input unprot;
      reg [`ADDR_W-1:0] t;
      begin
         t = a;
         t[`PROT_BIT_SEL] = unprot;
         t[`PROT_BIT_ONE] = 1'b1;
         t[`PROT_BIT_ZERO] = 1'b0;
         prot_addr = t;
      end
   endfunction

   // mask read data to the active width
   function [`DATA_W-1:0] byte_mode_data;
      input [`DATA_W-1:0] d;
      input ws;
      begin
         if (ws)
            byte_mode_data = d;
         else
            byte_mode_data = {8'h00, d[7:0]};
      end
   endfunction

   // main sequencer
   always @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= {`CNT_W{1'b0}};
         op_reg <= 3'h0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
         flash_busy <= 1'b0;
         chip_en_n <= 1'b1;
         out_en_n <= 1'b1;
         wr_strobe_n <= 1'b1;
         hw_reset_n <= 1'b0; // reset pulse puts device in array read
         high_voltage_level <= 1'b0;
         word_sel <= 1'b1;
         write_protect_n <= 1'b0;
         addr_out <= 20'h0_0000;
         data_out <= 16'h0000;
         data_oe <= 16'h0000;
      end else begin
         rsp_valid <= 1'b0;
         flash_busy <= busy_sync;
         write_protect_n <= ~boot_lock;
         case (state_reg)
            ST_IDLE: begin
               hw_reset_n <= 1'b1;
               high_voltage_level <= temp_unprotect;
               chip_en_n <= 1'b1;
               out_en_n <= 1'b1;
               wr_strobe_n <= 1'b1;
               data_oe <= 16'h0000;
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  op_reg <= op_code;
                  word_sel <= ~byte_mode;
                  addr_out <= pin_addr(req_addr, byte_mode);
                  data_out <= req_wdata;
                  if (byte_mode)
                     data_out[`DATA_W-1] <= req_addr[0];
                  cnt_reg <= {`CNT_W{1'b0}};
                  case (op_code)
                     `OP_READ: begin
                        chip_en_n <= 1'b0;
                        out_en_n <= 1'b0;
                        wr_strobe_n <= 1'b1;
                        data_oe <= byte_mode ? 16'h8000 : 16'h0000;
                        state_reg <= ST_READ;
                     end
                     `OP_WRITE: begin
                        chip_en_n <= 1'b0;
                        data_oe <= wr_enables(byte_mode);
                        state_reg <= ST_WRITE;
                     end
                     `OP_PROTECT, `OP_UNPROTECT: begin
                        high_voltage_level <= 1'b1;
                        word_sel <= 1'b1;
                        addr_out <= prot_addr(req_addr[`ADDR_W-1:0],
                           op_code == `OP_UNPROTECT);
                        chip_en_n <= 1'b0;
                        data_oe <= 16'h00ff;
                        state_reg <= ST_WRITE;
                     end
                     default: begin
                        hw_reset_n <= 1'b0;
                        high_voltage_level <= 1'b0;
                        state_reg <= ST_RESET;
                     end
                  endcase
               end
            end
            ST_READ: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == `ACCESS_CYC + 2) begin
                  // data passed the synchroniser by now
                  rsp_rdata <= byte_mode_data(data_sync, word_sel);
                  rsp_valid <= 1'b1;
                  chip_en_n <= 1'b1;
                  out_en_n <= 1'b1;
                  data_oe <= 16'h0000;
                  cnt_reg <= {`CNT_W{1'b0}};
                  state_reg <= ST_RECOVER;
               end
            end
            ST_WRITE: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == {`CNT_W{1'b0}})
                  wr_strobe_n <= 1'b0; // strobe after setup
               if (cnt_reg == `STROBE_CYC) begin
                  wr_strobe_n <= 1'b1; // device latches on rise
                  cnt_reg <= {`CNT_W{1'b0}};
                  state_reg <= ST_RECOVER;
               end
            end
            ST_RESET: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == `RESET_PULSE_CYC - 1) begin
                  hw_reset_n <= 1'b1;
                  cnt_reg <= {`CNT_W{1'b0}};
                  state_reg <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               chip_en_n <= 1'b1;
               data_oe <= 16'h0000;
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == `RECOVER_CYC - 1) begin
                  cnt_reg <= {`CNT_W{1'b0}};
                  if (op_reg == `OP_PROTECT || op_reg == `OP_UNPROTECT)
                     high_voltage_level <= temp_unprotect;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

endmodule // flash_bus_host
`default_nettype wire

/* testbench/flash_bus_host_assertions.sv */
/*
 checker for the flash bus host: pin relations on the device side.
 assumes the host top ports and the shared defines header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defines.vh"

module flash_bus_host_chk (
   // clock, reset and user side
   input wire logic clk, reset_n, req_valid, req_ready, byte_mode, boot_lock, rsp_valid,
   input wire logic [2:0] op_code,
   input wire logic [`ADDR_W:0] req_addr,
   // flash pins
   input wire logic chip_en_n, out_en_n, wr_strobe_n, hw_reset_n, high_voltage_level,
   input wire logic word_sel, write_protect_n,
   input wire logic [`ADDR_W-1:0] addr_out,
   input wire logic [`DATA_W-1:0] data_out, data_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // request taken this edge, address seen at that edge
   wire logic take = req_valid && req_ready;
   logic [`ADDR_W:0] addr_q;
   always @(posedge clk) addr_q <= req_addr;

   chk_read_strobe: assert property (!out_en_n |-> wr_strobe_n)
      else $error("write strobe low while output enabled");
   chk_strobe_select: assert property (!wr_strobe_n |-> !chip_en_n && out_en_n && hw_reset_n)
      else $error("strobe low without select or with output enable");
   chk_read_pins: assert property (!out_en_n |-> !chip_en_n && hw_reset_n && data_oe[14:0] == 15'h0000)
      else $error("read cycle with bad control or driven data");
   chk_strobe_width: assert property ($fell(wr_strobe_n) |-> !wr_strobe_n [*2] ##1 wr_strobe_n)
      else $error("write strobe width wrong");
   // answer: one wait edge, six counted edges, then the pulse is seen
   chk_read_answer: assert property (take && op_code == `OP_READ |-> ##8 rsp_valid)
      else $error("read answer missing");
   chk_word_addr: assert property (take && op_code == `OP_READ && !byte_mode
      |=> word_sel && addr_out == addr_q[19:0])
      else $error("word address wrong");
   chk_byte_addr: assert property (take && op_code == `OP_READ && byte_mode
      |=> !word_sel && addr_out == addr_q[20:1] && data_oe[15] && data_out[15] == addr_q[0])
      else $error("byte address wrong");
   chk_protect_addr: assert property (take && op_code == `OP_PROTECT |-> ##[1:4] !wr_strobe_n
      && high_voltage_level && !addr_out[6] && addr_out[1:0] == 2'b10)
      else $error("protect cycle wrong");
   chk_unprot_addr: assert property (take && op_code == `OP_UNPROTECT |-> ##[1:4] !wr_strobe_n
      && high_voltage_level && addr_out[6] && addr_out[1:0] == 2'b10)
      else $error("unprotect cycle wrong");
   chk_boot_lock: assert property ($past(reset_n) |-> write_protect_n == !$past(boot_lock))
      else $error("write protect pin wrong");
   // main scenarios seen
   cover property (take && op_code == `OP_READ && byte_mode);
   cover property ($fell(wr_strobe_n) && high_voltage_level);
   cover property ($fell(hw_reset_n));
endmodule // flash_bus_host_chk

bind flash_bus_host flash_bus_host_chk chk_i (.clk, .reset_n, .req_valid, .req_ready,
   .byte_mode, .boot_lock, .rsp_valid, .op_code, .req_addr, .chip_en_n, .out_en_n,
   .wr_strobe_n, .hw_reset_n, .high_voltage_level, .word_sel, .write_protect_n,
   .addr_out, .data_out, .data_oe);
`default_nettype wire

/* testbench/flash_device_model.sv */
/*
 behavioural flash device with data pin resolution.
 assumes the host drives its data pins through data_out and data_oe.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_device_model #(
   parameter ACC_NS = 60
) (
   // control and address pins
   input wire logic chip_en_n, out_en_n, wr_strobe_n, hw_reset_n, high_voltage_level,
   input wire logic word_sel, write_protect_n,
   input wire logic [19:0] addr_out,
   // host side of data pins, resolved pins, status
   input wire logic [15:0] data_out, data_oe,
   output logic [15:0] data_in,
   output logic ready_busy_out
);
   logic [15:0] cmd_reg = 16'h0000;
   logic [15:0] hold = 16'hffff;
   logic [15:0] dev_q;
   logic prot_state = 1'b0;
   // boot erase refused while locked; no erase modelled
   wire logic boot_locked = ~write_protect_n;
   // drive only when selected, output enabled, strobe high, out of reset
   wire logic dev_oe = ~chip_en_n & ~out_en_n & wr_strobe_n & hw_reset_n;
   wire logic [15:0] mask = word_sel ? 16'hffff : 16'h00ff;
   // array data from address only, command register never shadows it
   assign #(ACC_NS) dev_q = word_sel ? addr_out[15:0] ^ 16'ha5c3 :
      {8'h00, {addr_out[6:0], data_in[15]} ^ 8'h3c};
   assign ready_busy_out = 1'b1;
   // released bits show the inverse of the last driven value
   always @(negedge dev_oe) hold <= ~dev_q;
   always @* begin
      for (int i = 0; i < 16; i++)
         data_in[i] = data_oe[i] ? data_out[i] : (dev_oe && mask[i]) ? dev_q[i] : hold[i];
   end
   // command latch, loaded on strobe rise, cleared by reset
   always @(posedge wr_strobe_n or negedge hw_reset_n) begin
      if (!hw_reset_n) cmd_reg <= 16'h0000;
      else if (!chip_en_n && out_en_n) cmd_reg <= data_in;
   end
   // sector protect state from high voltage cycles
   always @(negedge wr_strobe_n) begin
      if (high_voltage_level && !chip_en_n && out_en_n && addr_out[1] && !addr_out[0])
         prot_state <= ~addr_out[6];
   end
endmodule // flash_device_model
`default_nettype wire

/* testbench/tb_top.sv */
/*
 self-checking bench for the flash bus host with a device model.
 assumes the host design, its defines header and the device model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defines.vh"

module tb_top;
   logic clk = 0, reset_n = 0, req_valid = 0, byte_mode = 0, temp_unprotect = 0, boot_lock = 0;
   logic [2:0] op_code = 3'h0;
   logic [20:0] req_addr = 21'h00_0000, st, a;
   logic [15:0] req_wdata = 16'h0000, rd;
   wire logic req_ready, rsp_valid, flash_busy, chip_en_n, out_en_n, wr_strobe_n, hw_reset_n;
   wire logic high_voltage_level, word_sel, write_protect_n, ready_busy_out;
   wire logic [15:0] rsp_rdata, data_in, data_out, data_oe;
   wire logic [19:0] addr_out;
   int err_count = 0, num_checks = 0;
   // clock and strobe capture
   always #10 clk = ~clk;
   always @(negedge wr_strobe_n) st = {high_voltage_level, addr_out};
   flash_bus_host dut (.clk, .reset_n, .req_valid, .op_code, .req_addr, .req_wdata, .byte_mode,
      .temp_unprotect, .boot_lock, .req_ready, .rsp_valid, .rsp_rdata, .flash_busy, .chip_en_n,
      .out_en_n, .wr_strobe_n, .hw_reset_n, .high_voltage_level, .word_sel, .write_protect_n,
      .addr_out, .data_in, .data_out, .data_oe, .ready_busy_out);
   flash_device_model model (.chip_en_n, .out_en_n, .wr_strobe_n, .hw_reset_n,
      .high_voltage_level, .word_sel, .write_protect_n, .addr_out, .data_out, .data_oe,
      .data_in, .ready_busy_out);

   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one request, held until taken, then wait for idle
   task automatic req(input logic [2:0] op, input logic [20:0] ad, input logic [15:0] d);
      @(posedge clk);
      #1 op_code = op;
      req_addr = ad;
      req_wdata = d;
      req_valid = 1;
      rd = 16'hxxxx;
      do @(posedge clk); while (req_ready !== 1'b1);
      #1 req_valid = 0;
      repeat (60) begin
         @(posedge clk);
         #1;
         if (rsp_valid === 1'b1) rd = rsp_rdata;
         if (req_ready === 1'b1) break;
      end
   endtask
   task automatic t_read_word;
      req(`OP_READ, 21'h0a_5a5c, 16'h0000);
      chk(rd, 16'h5a5c ^ 16'ha5c3);
      chk(flash_busy, 1'b0);
      $display("read_word done");
   endtask
   task automatic t_read_byte;
      byte_mode = 1;
      req(`OP_READ, 21'h13_5679, 16'h0000);
      chk(rd, 16'h0079 ^ 16'h003c);
      byte_mode = 0;
      $display("read_byte done");
   endtask
   task automatic t_write_keep;
      req(`OP_WRITE, 21'h00_0555, 16'h00aa);
      chk(model.cmd_reg, 16'h00aa);
      req(`OP_READ, 21'h00_0555, 16'h0000);
      chk(rd, 16'h0555 ^ 16'ha5c3);
      $display("write_keep done");
   endtask
   task automatic t_protect;
      for (int u = 0; u < 2; u++) begin
         a = u ? 21'h0a_bc01 : 21'h0a_bc41;
         req(u ? `OP_UNPROTECT : `OP_PROTECT, a, 16'h0000);
         chk({st[20], st[6], st[1:0]}, {2'b01, u[0], 2'b10});
         chk(st[19:7], a[19:7]);
      end
      $display("protect done");
   endtask
   task automatic t_reset_read;
      req(`OP_RESET, 21'h00_0000, 16'h0000);
      chk(model.cmd_reg, 16'h0000);
      req(`OP_WRITE, 21'h00_0555, 16'h0033);
      req(3'h7, 21'h00_0000, 16'h0000);
      chk(model.cmd_reg, 16'h0000);
      req(`OP_READ, 21'h0f_1234, 16'h0000);
      chk(rd, 16'h1234 ^ 16'ha5c3);
      $display("reset_read done");
   endtask
   task automatic t_temp_lock;
      temp_unprotect = 1;
      boot_lock = 1;
      repeat (3) @(posedge clk);
      chk({high_voltage_level, write_protect_n}, 2'b10);
      req(`OP_WRITE, 21'h00_02aa, 16'h0055);
      chk(model.cmd_reg, 16'h0055);
      #1 temp_unprotect = 0;
      boot_lock = 0;
      $display("temp_lock done");
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      #1 reset_n = 1;
      t_read_word();
      t_read_byte();
      t_write_keep();
      t_protect();
      t_reset_read();
      t_temp_lock();
      final_report();
   end
   // watchdog, about thirty times the expected run
   initial begin
      #100000;
      err_count++;
      final_report();
   end
endmodule // tb_top
`default_nettype wire
